// File: design/pio_top.v
// Parallel I/O ports with an AXI4-Lite register slave.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "pio_consts.vh"
// Contract
// - Every pin level is sampled each clock cycle regardless of direction.
// - Input pin: write goes to latch, read returns sampled pin.
// - Input pin read-modify-write uses pin level, result to latch.
// - Output pin: write drives latch and pin, read returns latch.
// - Output pin read-modify-write uses latch, changing the pin.
// - Ports 2,3,4,6,7,8 have per-pin push-pull or open-drain select; port 8 has no address for its select and stays push-pull.
// - One threshold bit per byte; ports 2,3,5 use two bits.
// - Direction and drive mode are independent of threshold choice.
// - Alternate output reaches pin only when direction is output.
// - Pin drives latch AND alternate data, except PWM outputs.
// - All direction bits reset to zero, meaning input.
// - Alternate input of an output pin sees the output latch.
// - Port 0 bus lines switch direction by hardware under alternate use.
// - Port 3 has fifteen lines; line 14 is absent.
// - Port 5 is sixteen input-only lines without driver.
// - Ports 0,1 two bytes; port 2 sixteen; ports 4,6,7,8 eight lines.
// - Port 4 alternate output carries segment address bits 23 to 16.
module pio_top (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Pads, nine ports of sixteen bits packed port 0 lowest
    input wire [143:0] pin_i,
    output wire [143:0] pin_o,
    output wire [143:0] pin_oe_n,
    // Alternate functions
    input wire [143:0] alt_out,
    input wire [15:0] port0_auto_dir,
    input wire [23:0] segment_address_bits,
    output wire [143:0] alt_in,
    // Threshold selects towards the pad cells
    output wire [8:0] input_threshold_select,
    output wire [3:0] ext_input_threshold_select
);
    // ----------------------------------------------------------------------
    // Address decode helpers
    // ----------------------------------------------------------------------
    function [3:0] f_grp;
        input [7:0] a;
        begin
            f_grp = (a[7:5] == 3'b111) ? 4'h0 : {1'b0, a[`PIO_GRP_MSB:`PIO_GRP_LSB]};
        end
    endfunction
    // Kind 7 holds port 8, whose only register is its data word.
    function [3:0] f_port;
        input [7:0] a;
        begin
            f_port = (a[7:5] == 3'b111) ? 4'h8 : {1'b0, a[4:2]};
        end
    endfunction
    function f_mapped;
        input [7:0] a;
        begin
            if (a[7:5] == 3'b111) begin
                f_mapped = (a[4:2] == 3'b000);
            end else if (a[7:5] == 3'b110) begin
                f_mapped = (a[4:2] <= 3'b001);
            end else begin
                f_mapped = 1'b1;
            end
        end
    endfunction

    // ----------------------------------------------------------------------
    // Write channel: address and data may come in either order
    // ----------------------------------------------------------------------
    reg aw_have_q;
    reg w_have_q;
    reg [7:0] aw_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    reg [8:0] thr_q;
    reg [3:0] xthr_q;
    wire do_write;
    wire [15:0] wstrb16;
    wire [3:0] wgrp;
    wire [3:0] wport;
    wire wmap;
    wire rmw_op;
    wire [15:0] rd_data [0:8];
    wire [15:0] rd_pin [0:8];
    wire [15:0] rd_dir [0:8];
    wire [15:0] rd_ods [0:8];
    wire [15:0] rd_alt [0:8];
    wire [15:0] wr_val;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wstrb16 = {{8{ws_q[1]}}, {8{ws_q[0]}}};
    assign wmap = f_mapped(aw_q);
    assign wgrp = f_grp(aw_q);
    assign wport = f_port(aw_q);
    assign rmw_op = (wgrp == `PIO_GRP_RMW);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIO_RESP_OKAY;
            thr_q <= 9'h000;
            xthr_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmap ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
                if (wmap && wgrp == `PIO_GRP_THR && wport == `PIO_THR_INT && ws_q[0]) begin
                    thr_q <= {ws_q[1] ? wd_q[8] : thr_q[8], wd_q[7:0]};
                end
                if (wmap && wgrp == `PIO_GRP_THR && wport == `PIO_THR_EXT && ws_q[0]) begin
                    xthr_q <= wd_q[3:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read-modify-write: the old value is the pin for inputs, the latch for
    // outputs, which is what rd_data already gives; the word is XORed into it.
    assign wr_val = rmw_op ? (rd_data[wport] ^ wd_q[15:0]) : wd_q[15:0];

    // ----------------------------------------------------------------------
    // Ports
    // ----------------------------------------------------------------------
    localparam [143:0] MASKS = {`PIO_MASK_P8, `PIO_MASK_P7, `PIO_MASK_P6, `PIO_MASK_P5,
        `PIO_MASK_P4, `PIO_MASK_P3, `PIO_MASK_P2, `PIO_MASK_P1, `PIO_MASK_P0};
    localparam [8:0] ODS_SET = `PIO_ODS_PORTS;
    localparam [8:0] OUT_SET = `PIO_OUT_PORTS;
    localparam [8:0] AUTO_SET = `PIO_AUTO_PORTS;
    localparam [8:0] PWM_SET = `PIO_PWM_PORTS;

    genvar g;
    generate
        for (g = 0; g < `PIO_NPORT; g = g + 1) begin : g_port
            wire sel;
            wire [15:0] aout;
            assign sel = do_write && wmap && (wport == g);
            // Port 4 carries the segment address as its alternate output.
            if (g == 4) begin : g_seg
                assign aout = {8'h00, segment_address_bits[23:`PIO_SEG_LSB]};
            end else begin : g_plain
                assign aout = alt_out[g*16 +: 16];
            end
            pio_line #(
                .MASK(MASKS[g*16 +: 16]),
                .OUT_OK(OUT_SET[g]),
                .ODS_OK(ODS_SET[g]),
                .AUTO_DIR(AUTO_SET[g]),
                .PWM_ALT(PWM_SET[g])
            ) u_line (
                .aclk(aclk),
                .aresetn(aresetn),
                .we_data(sel && (wgrp == `PIO_GRP_DATA || rmw_op)),
                .we_dir(sel && wgrp == `PIO_GRP_DIR),
                .we_ods(sel && wgrp == `PIO_GRP_ODS),
                .we_alt(sel && wgrp == `PIO_GRP_ALT),
                .wdata(wr_val),
                .wstrb16(wstrb16),
                .alt_out(aout),
                .alt_auto_dir(g == 0 ? port0_auto_dir : `PIO_ZERO16),
                .alt_in(alt_in[g*16 +: 16]),
                .pin_i(pin_i[g*16 +: 16]),
                .pin_o(pin_o[g*16 +: 16]),
                .pin_oe_n(pin_oe_n[g*16 +: 16]),
                .rd_data(rd_data[g]),
                .rd_pin(rd_pin[g]),
                .rd_dir(rd_dir[g]),
                .rd_ods(rd_ods[g]),
                .rd_alt(rd_alt[g])
            );
        end
    endgenerate

    assign input_threshold_select = thr_q;
    assign ext_input_threshold_select = xthr_q;

    // ----------------------------------------------------------------------
    // Read channel: one cycle after the address is taken
    // ----------------------------------------------------------------------
    wire [3:0] rgrp;
    wire [3:0] rport;
    reg [15:0] rsel;

    assign s_axi_arready = !s_axi_rvalid;
    assign rgrp = f_grp(s_axi_araddr);
    assign rport = f_port(s_axi_araddr);

    always @* begin
        rsel = `PIO_ZERO16;
        case (rgrp)
            `PIO_GRP_DATA: rsel = rd_data[rport];
            `PIO_GRP_DIR: rsel = rd_dir[rport];
            `PIO_GRP_ODS: rsel = rd_ods[rport];
            `PIO_GRP_ALT: rsel = rd_alt[rport];
            `PIO_GRP_RMW: rsel = rd_data[rport];
            `PIO_GRP_PIN: rsel = rd_pin[rport];
            `PIO_GRP_THR: rsel = (rport == `PIO_THR_INT) ? {7'h00, thr_q}
                                                        : {12'h000, xthr_q};
            default: rsel = `PIO_ZERO16;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PIO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= f_mapped(s_axi_araddr) ? {16'h0000, rsel} : 32'h0000_0000;
            s_axi_rresp <= f_mapped(s_axi_araddr) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // pio_top

// File: design/pio_consts.vh
// Constants for the parallel I/O port block: register map, widths and reset values.
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH
// ----------------------------------------------------------------------
// Register index (byte address is index times four)
// ----------------------------------------------------------------------
`define PIO_NPORT 9
`define PIO_IDX_W 4
// Per-port register groups: data, direction, open drain, alternate enable, read-modify-write, pin level.
`define PIO_GRP_DATA 4'h0
`define PIO_GRP_DIR 4'h1
`define PIO_GRP_ODS 4'h2
`define PIO_GRP_ALT 4'h3
`define PIO_GRP_RMW 4'h4
`define PIO_GRP_PIN 4'h5
// Threshold registers live in group 6, port field 0 and 1.
`define PIO_GRP_THR 4'h6
`define PIO_THR_INT 4'h0
`define PIO_THR_EXT 4'h1
`define PIO_ADDR_W 8
// Address layout: kind in bits [7:5], port in bits [4:2].
`define PIO_GRP_MSB 7
`define PIO_GRP_LSB 5
// ----------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------
`define PIO_W 16
// Valid-line masks per port 0..8.
`define PIO_MASK_P0 16'hFFFF
`define PIO_MASK_P1 16'hFFFF
`define PIO_MASK_P2 16'hFFFF
`define PIO_MASK_P3 16'hBFFF
`define PIO_MASK_P4 16'h00FF
`define PIO_MASK_P5 16'hFFFF
`define PIO_MASK_P6 16'h00FF
`define PIO_MASK_P7 16'h00FF
`define PIO_MASK_P8 16'h00FF
// Open-drain capable ports as a bit set over port numbers.
`define PIO_ODS_PORTS 9'h1DC
// Output-capable ports (port 5 is input only).
`define PIO_OUT_PORTS 9'h1DF
// Ports with hardware-switched direction under alternate function.
`define PIO_AUTO_PORTS 9'h001
// PWM-driven alternate outputs bypass the latch AND; port 7 carries them.
`define PIO_PWM_PORTS 9'h080
// Threshold bit count: internal word 9 bits, external word 4 bits.
`define PIO_THR_INT_W 9
`define PIO_THR_EXT_W 4
// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PIO_ZERO16 16'h0000
`define PIO_ONES16 16'hFFFF
`define PIO_RESP_OKAY 2'b00
`define PIO_RESP_SLVERR 2'b10
`define PIO_SEG_LSB 16
`endif

// File: design/pio_line.v
// One port: output latch, direction, open drain, pin sampling and alternate mux.
`timescale 1ns/10ps
`include "pio_consts.vh"
module pio_line #(
    parameter [15:0] MASK = 16'hFFFF,
    parameter OUT_OK = 1,
    parameter ODS_OK = 1,
    parameter AUTO_DIR = 0,
    parameter PWM_ALT = 0
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Software writes
    input wire we_data,
    input wire we_dir,
    input wire we_ods,
    input wire we_alt,
    input wire [15:0] wdata,
    input wire [15:0] wstrb16,
    // Alternate function side
    input wire [15:0] alt_out,
    input wire [15:0] alt_auto_dir,
    output wire [15:0] alt_in,
    // Pads
    input wire [15:0] pin_i,
    output reg [15:0] pin_o,
    output reg [15:0] pin_oe_n,
    // Read-back
    output wire [15:0] rd_data,
    output wire [15:0] rd_pin,
    output wire [15:0] rd_dir,
    output wire [15:0] rd_ods,
    output wire [15:0] rd_alt
);
    reg [15:0] latch_q;
    reg [15:0] dir_q;
    reg [15:0] ods_q;
    reg [15:0] alt_q;
    reg [15:0] in_q;
    wire [15:0] dir_eff;
    wire [15:0] drive;

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= `PIO_ZERO16;
            dir_q <= `PIO_ZERO16;
            ods_q <= `PIO_ZERO16;
            alt_q <= `PIO_ZERO16;
            in_q <= `PIO_ZERO16;
        end else begin
            // Sampled every cycle whatever the direction.
            in_q <= pin_i & MASK;
            if (we_data && OUT_OK) begin
                // Input or output, a write lands in the latch.
                latch_q <= ((latch_q & ~wstrb16) | (wdata & wstrb16)) & MASK;
            end
            if (we_dir && OUT_OK) begin
                dir_q <= ((dir_q & ~wstrb16) | (wdata & wstrb16)) & MASK;
            end
            if (we_ods && ODS_OK) begin
                ods_q <= ((ods_q & ~wstrb16) | (wdata & wstrb16)) & MASK;
            end
            if (we_alt) begin
                alt_q <= ((alt_q & ~wstrb16) | (wdata & wstrb16)) & MASK;
            end
        end
    end

    // Auto-switching lines follow the alternate function's own direction.
    assign dir_eff = (AUTO_DIR ? ((alt_q & alt_auto_dir) | (~alt_q & dir_q)) : dir_q)
                     & MASK;
    // PWM outputs bypass the latch; others are ANDed with it.
    assign drive = (alt_q & (PWM_ALT ? alt_out : (alt_out & latch_q)))
                   | (~alt_q & latch_q);

    // ----------------------------------------------------------------------
    // Pad drive; threshold choice never enters here
    // ----------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_o <= `PIO_ZERO16;
            pin_oe_n <= `PIO_ONES16;
        end else begin
            pin_o <= drive;
            // Open drain releases the pad whenever it would drive a one.
            pin_oe_n <= (OUT_OK ? ~dir_eff : `PIO_ONES16)
                        | (ODS_OK ? (ods_q & drive) : `PIO_ZERO16);
        end
    end

    // Output lines feed their own latch back to the alternate input.
    assign alt_in = ((dir_q & latch_q) | (~dir_q & in_q)) & MASK;
    assign rd_data = alt_in;
    assign rd_pin = in_q;
    assign rd_dir = dir_q;
    assign rd_ods = ods_q;
    assign rd_alt = alt_q;
endmodule // pio_line

// File: bench/pio_top_chk.sv
// Port-level assertions for the parallel I/O block.
`timescale 1ns/10ps
module pio_top_chk (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Pads and pad-cell controls
    input wire [143:0] pin_i,
    input wire [143:0] pin_oe_n,
    input wire [143:0] alt_in,
    input wire [8:0] input_threshold_select,
    input wire [3:0] ext_input_threshold_select
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    dir_reset_a: assert property ($rose(aresetn) |-> &pin_oe_n)
        else $error("pads enabled after reset");
    port5_drive_a: assert property (&pin_oe_n[95:80])
        else $error("input-only port drives a pad");
    line14_drive_a: assert property (pin_oe_n[62])
        else $error("absent port line drives");
    upper_byte_a: assert property (&{pin_oe_n[79:72], pin_oe_n[111:104],
        pin_oe_n[127:120], pin_oe_n[143:136]})
        else $error("missing upper byte drives");
    // The pin side of the compare and the reset test are one cycle back, so a reset edge is skipped.
    pin_sample_a: assert property ($past(aresetn) |->
        alt_in[95:80] == $past(pin_i[95:80]))
        else $error("pin not sampled every cycle");
    thr_write_a: assert property ($past(aresetn) &&
        $changed({input_threshold_select, ext_input_threshold_select}) |-> $rose(s_axi_bvalid))
        else $error("threshold moved without a write");
    pad_write_a: assert property ($past(aresetn) && $changed(pin_oe_n[31:16])
        |-> $past(s_axi_bvalid))
        else $error("direction moved without a write");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000)
        else $error("read taken while data pending or upper half set");
    slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    rd_stall_c: cover property (s_axi_rvalid && !s_axi_rready);
    auto_dir_c: cover property (pin_oe_n[15:0] == 16'h00FF);
endmodule // pio_top_chk

bind pio_top pio_top_chk pio_top_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_i(pin_i), .pin_oe_n(pin_oe_n), .alt_in(alt_in),
    .input_threshold_select(input_threshold_select),
    .ext_input_threshold_select(ext_input_threshold_select));

// File: bench/pio_pad_model.sv
// Pad-side model: external drivers and pull-ups on every port line.
`timescale 1ns/10ps
module pio_pad_model (
    // Clock
    input wire aclk,
    // Pads of the block
    input wire [143:0] pin_o,
    input wire [143:0] pin_oe_n,
    output wire [143:0] pin_i,
    // Scenario control
    input wire [143:0] ext_val,
    input wire [143:0] ext_en,
    output logic clash_seen
);
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // A released line with no device driving it goes to the pull-up level, never keeps its last value.
    assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
    initial clash_seen = 1'b0;
    // Devices drive only input lines; a clash means the sequence was wrong.
    always @(posedge aclk) begin
        if (|(~pin_oe_n & ext_en)) clash_seen <= 1'b1;
    end
endmodule // pio_pad_model

// File: bench/test_pio_top.sv
// Self-checking bench for the parallel I/O port block.
`timescale 1ns/10ps
`include "pio_consts.vh"
module test_pio_top;
    localparam logic [1:0] OK = `PIO_RESP_OKAY;
    localparam logic [1:0] ERR = `PIO_RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, clash_seen;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [143:0] pin_i, pin_o, pin_oe_n, alt_in;
    logic [143:0] alt_out = 144'h0, ext_val = 144'h0, ext_en = 144'h0;
    logic [15:0] port0_auto_dir = 16'h0000;
    logic [23:0] segment_address_bits = 24'h00_0000;
    logic [8:0] thr;
    logic [3:0] ext_thr;
    int error_cnt = 0;
    int checks = 0;
    always #5 aclk = ~aclk;
    pio_top pio_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .alt_out(alt_out), .port0_auto_dir(port0_auto_dir), .alt_in(alt_in),
        .segment_address_bits(segment_address_bits), .input_threshold_select(thr),
        .ext_input_threshold_select(ext_thr));
    pio_pad_model pio_pad_model_inst (.aclk(aclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pin_i(pin_i), .ext_val(ext_val), .ext_en(ext_en), .clash_seen(clash_seen));
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] ad(input int k, input int p);
        return 8'(k * 32 + p * 4);
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        chk(n, {14'h0, e}, {14'h0, g});
    endtask
    // A nonzero st holds the response ready low for st cycles.
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er, input int st);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (st == 0);
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == st) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        chk("bvalid", 16'h0001, {15'h0, s_axi_bvalid});
        s_axi_bready <= 1'b0;
        chk_resp("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er, input int st);
        int n;
        @(posedge aclk);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (st == 0);
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == st) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        chk("rvalid", 16'h0001, {15'h0, s_axi_rvalid});
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata[15:0]);
        chk_resp("rresp", er, s_axi_rresp);
    endtask
    // Pads follow a write two edges after it is taken.
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_io;
        for (int p = 0; p < 8; p++) rd(ad(1, p), 16'h0000, OK, 0);
        chk("all_oe_n", 16'h0001, {15'h0, &pin_oe_n});
        @(posedge aclk);
        ext_en[31:16] <= 16'hFFFF;
        ext_val[31:16] <= 16'hA5C3;
        wr(ad(0, 1), 16'h1234, OK, 0);
        rd(ad(0, 1), 16'hA5C3, OK, 0);
        rd(ad(5, 1), 16'hA5C3, OK, 0);
        chk("alt_in", 16'hA5C3, alt_in[31:16]);
        @(posedge aclk);
        ext_en[31:16] <= 16'h0000;
        wr(ad(1, 1), 16'hFFFF, OK, 0);
        settle;
        chk("pin_o", 16'h1234, pin_o[31:16]);
        chk("pin_oe_n", 16'h0000, pin_oe_n[31:16]);
        rd(ad(0, 1), 16'h1234, OK, 0);
        rd(ad(5, 1), 16'h1234, OK, 0);
        wr(ad(4, 1), 16'h00FF, OK, 0);
        rd(ad(0, 1), 16'h12CB, OK, 0);
        settle;
        chk("pin_o", 16'h12CB, pin_o[31:16]);
        wr(ad(1, 1), 16'h0000, OK, 0);
        @(posedge aclk);
        ext_en[31:16] <= 16'hFFFF;
        ext_val[31:16] <= 16'h0F0F;
        wr(ad(4, 1), 16'hFFFF, OK, 0);
        rd(ad(0, 1), 16'h0F0F, OK, 0);
        @(posedge aclk);
        ext_en[31:16] <= 16'h0000;
        wr(ad(1, 1), 16'hFFFF, OK, 0);
        rd(ad(0, 1), 16'hF0F0, OK, 0);
        $display("test io done");
    endtask
    task automatic t_alt;
        @(posedge aclk);
        alt_out[31:16] <= 16'h5A5A;
        alt_out[119:112] <= 8'hA5;
        wr(ad(0, 1), 16'hFFFF, OK, 0);
        wr(ad(3, 1), 16'hFFFF, OK, 0);
        settle;
        chk("pin_o", 16'h5A5A, pin_o[31:16]);
        wr(ad(0, 1), 16'h0F0F, OK, 0);
        settle;
        chk("pin_o", 16'h0A0A, pin_o[31:16]);
        chk("alt_in", 16'h0F0F, alt_in[31:16]);
        wr(ad(1, 1), 16'h0000, OK, 0);
        settle;
        chk("pin_oe_n", 16'hFFFF, pin_oe_n[31:16]);
        wr(ad(3, 7), 16'h00FF, OK, 0);
        wr(ad(1, 7), 16'h00FF, OK, 0);
        settle;
        chk("pwm_pin_o", 16'h00A5, {8'h00, pin_o[119:112]});
        $display("test alternate done");
    endtask
    task automatic t_misc;
        wr(ad(2, 1), 16'hFFFF, OK, 0);
        rd(ad(2, 1), 16'h0000, OK, 0);
        wr(ad(2, 2), 16'hFFFF, OK, 0);
        wr(ad(1, 2), 16'hFFFF, OK, 0);
        wr(ad(0, 2), 16'h00FF, OK, 0);
        settle;
        chk("od_oe_n", 16'h00FF, pin_oe_n[47:32]);
        chk("od_pin", 16'h00FF, pin_i[47:32]);
        wr(ad(1, 5), 16'hFFFF, OK, 0);
        rd(ad(1, 5), 16'h0000, OK, 0);
        wr(ad(1, 3), 16'hFFFF, OK, 0);
        wr(ad(0, 3), 16'hFFFF, OK, 0);
        rd(ad(0, 3), 16'hBFFF, OK, 0);
        wr(ad(0, 4), 16'hFFFF, OK, 0);
        rd(ad(0, 4), 16'h00FF, OK, 0);
        wr(ad(6, 0), 16'hFFFF, OK, 0);
        rd(ad(6, 0), 16'h01FF, OK, 0);
        wr(ad(6, 1), 16'hFFFF, OK, 0);
        rd(ad(6, 1), 16'h000F, OK, 3);
        chk("thr", 16'h1FFF, {3'h0, ext_thr, thr});
        rd(ad(1, 2), 16'hFFFF, OK, 0);
        wr(8'hCC, 16'h1234, ERR, 3);
        rd(8'hE4, 16'h0000, ERR, 0);
        wr(8'hE0, 16'hFFFF, OK, 0);
        rd(8'hE0, 16'h00FF, OK, 0);
        $display("test misc done");
    endtask
    task automatic t_bus;
        @(posedge aclk);
        port0_auto_dir <= 16'hFF00;
        segment_address_bits <= 24'hC3_0000;
        wr(ad(3, 0), 16'hFFFF, OK, 0);
        wr(ad(3, 4), 16'h00FF, OK, 0);
        wr(ad(1, 4), 16'h00FF, OK, 0);
        settle;
        chk("auto_oe_n", 16'h00FF, pin_oe_n[15:0]);
        chk("seg_pin_o", 16'h00C3, {8'h00, pin_o[71:64]});
        chk("clash", 16'h0000, {15'h0, clash_seen});
        $display("test bus functions done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_io;
        t_alt;
        t_misc;
        t_bus;
        summarize;
    end
endmodule // test_pio_top
